// [src/dpx_pkg.sv]
// Purpose: Shared constants and carriers for the dual pointer data memory access block
// Assumes: 8-bit core, special registers reached through direct internal addressing
// Notes:   Strobe lengths are counted in core clock periods

package dpx_pkg;

  // Special register offsets
  localparam logic [7:0] PSEL_OFS       = 8'ha2;
  localparam logic [7:0] MCTL_OFS       = 8'h8e;
  // Pointer select register fields
  localparam int         PSEL_SEL_BIT   = 0;
  localparam int         PSEL_ZERO_BIT  = 2;
  localparam int         PSEL_FLAG_BIT  = 3;
  localparam logic [7:0] PSEL_RESET     = 8'h00;
  // Memory control register fields
  localparam int         MCTL_ALE_BIT   = 0;
  localparam int         MCTL_EXT_BIT   = 1;
  localparam int         MCTL_XRS_LO    = 2;
  localparam int         MCTL_STR_BIT   = 5;
  localparam logic [7:0] MCTL_RESET     = 8'h08;
  // Internal address split
  localparam logic [7:0] LOWER_TOP      = 8'h7f;
  // Expanded RAM geometry
  localparam int         EXPANDED_RAM_BYTES     = 1024;
  localparam int         EXPANDED_RAM_AW        = 10;
  localparam int         XSIZE_UNIT     = 256;
  // External strobe timing, clock periods
  localparam logic [4:0] STROBE_SHORT   = 5'd6;
  localparam logic [4:0] STROBE_LONG    = 5'd30;
  localparam logic [4:0] ADDR_CYCLES    = 5'd2;

  typedef enum logic [1:0] {DPX_DIRECT, DPX_INDIRECT, DPX_STACK} dpx_amode_t;
  typedef enum logic [2:0] {DPX_OP_NONE, DPX_OP_LOAD, DPX_OP_INC, DPX_OP_WLOW, DPX_OP_WHIGH} dpx_dpop_t;
  typedef enum logic [1:0] {DPX_IDLE, DPX_ADDR, DPX_STRB, DPX_HOLD} dpx_state_t;

  // Internal data space request from the core
  typedef struct packed {
    logic       valid;
    logic       wr;
    dpx_amode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpx_ireq_t;

  // Move-external request from the core
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic       use_ri;
    logic [7:0] ri;
    logic [7:0] wdata;
  } dpx_xreq_t;

  // Data pointer operation from the core
  typedef struct packed {
    dpx_dpop_t   op;
    logic [15:0] val;
  } dpx_dpcmd_t;

  // Multiplexed external bus pins
  typedef struct packed {
    logic [7:0] p0_out;
    logic       p0_oe;
    logic [7:0] p2_out;
    logic       p2_oe;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
  } dpx_bus_t;

endpackage : dpx_pkg

// [src/dpx_access.sv]
// Purpose: Dual data pointers, expanded RAM, internal RAM split and external data bus sequencing
// Assumes: Core issues one request at a time and waits while o_xbusy is high
// Notes:   Strobe length follows the stretch bit sampled when the address phase ends
`timescale 1ns/10ps

module dpx_access #(
  parameter int IRAM_BYTES = 256
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rst,
  input  wire dpx_pkg::dpx_ireq_t  i_ireq,
  output logic [7:0]              o_irdata,
  output logic                    o_sfr_other,
  input  wire dpx_pkg::dpx_dpcmd_t i_dpcmd,
  output logic [15:0]             o_data_pointer,
  input  wire dpx_pkg::dpx_xreq_t  i_xreq,
  output logic                    o_xbusy,
  output logic                    o_xdone,
  output logic [7:0]              o_xrdata,
  input  wire logic [7:0]         i_p0_in,
  output dpx_pkg::dpx_bus_t        o_bus
);
  import dpx_pkg::*;

  typedef struct packed {
    logic        sel;
    logic        flag;
    logic        ext_sel;
    logic [1:0]  xrs;
    logic        stretch;
    logic        ale_mode;
    logic [15:0] dp0;
    logic [15:0] dp1;
    dpx_state_t  st;
    logic [4:0]  cnt;
    logic        use_ri;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  ext_rdata;
    logic        done;
    logic        done_int;
    logic [7:0]  sfr_rdata;
    logic        rd_sfr;
    logic        sfr_other;
    dpx_bus_t    bus;
  } dpx_reg_t;

  dpx_reg_t    r_q;
  dpx_reg_t    r_d;
  logic [7:0]  iram [IRAM_BYTES];
  logic [7:0]  expanded_ram [EXPANDED_RAM_BYTES];
  logic [7:0]  iram_q;
  logic [7:0]  expanded_ram_q;
  logic [15:0] xaddr;
  logic [10:0] vis_size;
  logic        x_hit;
  logic        x_take;
  logic        i_sfr;
  logic        i_psel;
  logic        i_mctl;
  logic [7:0]  psel_rd;
  logic [7:0]  mctl_rd;
  logic [15:0] dp_cur;

  // Selected pointer feeds address and code-table reads
  assign dp_cur = r_q.sel ? r_q.dp1 : r_q.dp0;
  assign o_data_pointer = dp_cur;

  // Visible size grows in 256-byte steps from the size field
  assign vis_size = 11'((32'(r_q.xrs) + 32'd1) * XSIZE_UNIT);

  // Register-indirect forms only ever carry an 8-bit address
  assign xaddr  = i_xreq.use_ri ? {8'h00, i_xreq.ri} : dp_cur;
  assign x_take = i_xreq.valid && (r_q.st == DPX_IDLE);
  // Full 16-bit compare, so anything past the visible size leaves the chip
  assign x_hit  = !r_q.ext_sel && (xaddr < {5'h00, vis_size});

  // Direct addressing above the lower RAM lands in special register space
  assign i_sfr  = (i_ireq.mode == DPX_DIRECT) && (i_ireq.addr > LOWER_TOP);
  assign i_psel = i_sfr && (i_ireq.addr == PSEL_OFS);
  assign i_mctl = i_sfr && (i_ireq.addr == MCTL_OFS);

  // Read images; unimplemented bits read zero, the forced zero in bit 2 included
  always_comb begin
    psel_rd                = 8'h00;
    psel_rd[PSEL_SEL_BIT]  = r_q.sel;
    psel_rd[PSEL_ZERO_BIT] = 1'b0;
    psel_rd[PSEL_FLAG_BIT] = r_q.flag;
    mctl_rd                = 8'h00;
    mctl_rd[MCTL_ALE_BIT]  = r_q.ale_mode;
    mctl_rd[MCTL_EXT_BIT]  = r_q.ext_sel;
    mctl_rd[MCTL_XRS_LO +: 2] = r_q.xrs;
    mctl_rd[MCTL_STR_BIT]  = r_q.stretch;
  end

  // Next-state logic for registers, pointers and the external bus sequencer
  always_comb begin
    logic [15:0] nv;
    nv            = 16'h0000;
    r_d           = r_q;
    r_d.done      = 1'b0;
    r_d.done_int  = 1'b0;
    r_d.sfr_other = 1'b0;
    // Special register access
    if (i_ireq.valid) begin
      r_d.rd_sfr    = i_sfr;
      r_d.sfr_other = i_sfr && !i_psel && !i_mctl;
      r_d.sfr_rdata = i_psel ? psel_rd : (i_mctl ? mctl_rd : 8'h00);
      if (i_ireq.wr && i_psel) begin
        r_d.sel  = i_ireq.wdata[PSEL_SEL_BIT];
        r_d.flag = i_ireq.wdata[PSEL_FLAG_BIT];
      end
      if (i_ireq.wr && i_mctl) begin
        r_d.ale_mode = i_ireq.wdata[MCTL_ALE_BIT];
        r_d.ext_sel  = i_ireq.wdata[MCTL_EXT_BIT];
        r_d.xrs      = i_ireq.wdata[MCTL_XRS_LO +: 2];
        r_d.stretch  = i_ireq.wdata[MCTL_STR_BIT];
      end
    end
    // Pointer operations touch only the selected pointer
    if (i_dpcmd.op != DPX_OP_NONE) begin
      nv = dp_cur;
      unique case (i_dpcmd.op)
        DPX_OP_LOAD:  nv = i_dpcmd.val;
        DPX_OP_INC:   nv = dp_cur + 16'h0001;
        DPX_OP_WLOW:  nv = {dp_cur[15:8], i_dpcmd.val[7:0]};
        DPX_OP_WHIGH: nv = {i_dpcmd.val[7:0], dp_cur[7:0]};
        default:      nv = dp_cur;
      endcase
      if (r_q.sel) r_d.dp1 = nv;
      else         r_d.dp0 = nv;
    end
    // External bus sequencer
    unique case (r_q.st)
      DPX_IDLE: begin
        if (x_take && x_hit) begin
          r_d.done_int = 1'b1;
          r_d.done     = 1'b1;
        end else if (x_take) begin
          r_d.st         = DPX_ADDR;
          r_d.cnt        = ADDR_CYCLES - 5'd1;
          r_d.use_ri     = i_xreq.use_ri;
          r_d.wr         = i_xreq.wr;
          r_d.addr       = xaddr;
          r_d.wdata      = i_xreq.wdata;
          r_d.bus.ale    = 1'b1;
          r_d.bus.p0_out = xaddr[7:0];
          r_d.bus.p0_oe  = 1'b1;
          r_d.bus.p2_out = xaddr[15:8];
          r_d.bus.p2_oe  = !i_xreq.use_ri;
        end
      end
      DPX_ADDR: begin
        if (r_q.cnt != 5'd0) begin
          r_d.cnt = r_q.cnt - 5'd1;
        end else begin
          // Latch has captured the low byte; open the strobe window
          r_d.st         = DPX_STRB;
          r_d.cnt        = (r_q.stretch ? STROBE_LONG : STROBE_SHORT) - 5'd1;
          r_d.bus.ale    = 1'b0;
          r_d.bus.rd_n   = r_q.wr;
          r_d.bus.wr_n   = !r_q.wr;
          r_d.bus.p0_out = r_q.wdata;
          r_d.bus.p0_oe  = r_q.wr;
        end
      end
      DPX_STRB: begin
        if (r_q.cnt != 5'd0) begin
          r_d.cnt = r_q.cnt - 5'd1;
        end else begin
          // Sample read data on the last strobe cycle, before the strobe rises
          r_d.st        = DPX_HOLD;
          r_d.ext_rdata = r_q.wr ? r_q.ext_rdata : i_p0_in;
          r_d.bus.rd_n  = 1'b1;
          r_d.bus.wr_n  = 1'b1;
        end
      end
      DPX_HOLD: begin
        // One cycle of data hold after a write strobe, then release the bus
        r_d.st        = DPX_IDLE;
        r_d.bus.p0_oe = 1'b0;
        r_d.bus.p2_oe = 1'b0;
        r_d.done      = 1'b1;
      end
      // All four state codes are in use, so no default arm
    endcase
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      r_q          <= '0;
      r_q.sel      <= PSEL_RESET[PSEL_SEL_BIT];
      r_q.flag     <= PSEL_RESET[PSEL_FLAG_BIT];
      r_q.ext_sel  <= MCTL_RESET[MCTL_EXT_BIT];
      r_q.xrs      <= MCTL_RESET[MCTL_XRS_LO +: 2];
      r_q.stretch  <= MCTL_RESET[MCTL_STR_BIT];
      r_q.ale_mode <= MCTL_RESET[MCTL_ALE_BIT];
      r_q.st       <= DPX_IDLE;
      r_q.bus.rd_n <= 1'b1;
      r_q.bus.wr_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Memories have no reset; contents are undefined until written
  always_ff @(posedge i_mclk) begin
    if (i_ireq.valid && !i_sfr) begin
      // Stack and indirect forms always land in the 256-byte internal RAM
      if (i_ireq.wr) iram[i_ireq.addr] <= i_ireq.wdata;
      iram_q <= iram[i_ireq.addr];
    end
    if (x_take && x_hit) begin
      if (i_xreq.wr) expanded_ram[xaddr[EXPANDED_RAM_AW-1:0]] <= i_xreq.wdata;
      expanded_ram_q <= expanded_ram[xaddr[EXPANDED_RAM_AW-1:0]];
    end
  end

  // Outputs
  assign o_irdata    = r_q.rd_sfr ? r_q.sfr_rdata : iram_q;
  assign o_sfr_other = r_q.sfr_other;
  assign o_xbusy     = (r_q.st != DPX_IDLE);
  assign o_xdone     = r_q.done;
  assign o_xrdata    = r_q.done_int ? expanded_ram_q : r_q.ext_rdata;
  assign o_bus       = r_q.bus;

  // Helper: measure each strobe pulse width
  logic       strobe;
  logic [5:0] width_q;
  logic       long_q;
  assign strobe = !(r_q.bus.rd_n && r_q.bus.wr_n);
  always_ff @(posedge i_mclk) begin
    if (i_rst || !strobe) width_q <= 6'h00;
    else                  width_q <= width_q + 6'h01;
  end

  // Helper: stretch choice at strobe start; a register write mid-access must not skew the width checks
  always_ff @(posedge i_mclk) begin
    if (i_rst)        long_q <= 1'b0;
    else if (!strobe) long_q <= r_q.stretch;
  end

  // Register and pointer checks
  a_sel_write: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ireq.valid && i_ireq.wr && i_psel) |=> (r_q.sel == $past(i_ireq.wdata[0]))
    && (o_data_pointer == ($past(i_ireq.wdata[0]) ? r_q.dp1 : r_q.dp0)))
    else $error("pointer select not taken from write");
  a_bit2_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ireq.valid && !i_ireq.wr && i_psel) |=> (o_irdata[2] == 1'b0) && (o_irdata[0] == r_q.sel))
    else $error("pointer select read image wrong");
  a_flag_inert: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ireq.valid && i_ireq.wr && i_psel && (i_ireq.wdata[0] == r_q.sel) && (i_dpcmd.op == DPX_OP_NONE))
    |=> $stable(o_data_pointer))
    else $error("user flag disturbed the pointer");
  a_ptr_indep: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_dpcmd.op != DPX_OP_NONE && !r_q.sel) |=> $stable(r_q.dp1))
    else $error("pointer zero operation disturbed pointer one");
  a_reset_map: assert property (@(posedge i_mclk)
    i_rst |=> (!r_q.ext_sel && (r_q.xrs == 2'h2) && !r_q.sel && !r_q.flag)
    && (!o_xbusy && o_bus.rd_n && o_bus.wr_n))
    else $error("reset state of select or size field wrong");

  // External bus checks
  a_int_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
    (x_take && x_hit) |=> ($stable(o_bus) && o_xdone && !o_xbusy))
    else $error("on-chip access touched the bus");
  a_ext_start: assert property (@(posedge i_mclk) disable iff (i_rst)
    (x_take && r_q.ext_sel) |=> o_bus.ale && o_xbusy)
    else $error("external select did not start a bus cycle");
  a_above_size: assert property (@(posedge i_mclk) disable iff (i_rst)
    (x_take && !r_q.ext_sel && !i_xreq.use_ri && ((o_data_pointer[15:10] != 6'h00) || (o_data_pointer[9:8] > r_q.xrs)))
    |=> (o_xbusy && o_bus.ale && o_bus.p2_oe))
    else $error("pointer above visible size stayed on-chip");
  a_size_hit: assert property (@(posedge i_mclk) disable iff (i_rst)
    (x_take && !r_q.ext_sel && !i_xreq.use_ri && (o_data_pointer[15:10] == 6'h00) && (o_data_pointer[9:8] <= r_q.xrs))
    |=> (o_xdone && !o_xbusy))
    else $error("pointer inside visible size left the chip");
  a_ri_onchip: assert property (@(posedge i_mclk) disable iff (i_rst)
    (x_take && !r_q.ext_sel && i_xreq.use_ri) |=> (o_xdone && !o_xbusy))
    else $error("register-indirect access left the chip");
  a_short_strobe: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($rose(strobe) && !long_q) |-> strobe [*6] ##1 !strobe)
    else $error("short strobe length wrong");
  a_strobe_width: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(strobe) |-> ($past(width_q) == 6'(long_q ? STROBE_LONG : STROBE_SHORT) - 6'd1))
    else $error("strobe width wrong");
  a_ri_no_p2: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_xbusy && r_q.use_ri) |-> !o_bus.p2_oe)
    else $error("register-indirect access drove port two");
  a_dp_high: assert property (@(posedge i_mclk) disable iff (i_rst)
    (strobe && !r_q.use_ri) |-> (o_bus.p2_oe && o_bus.p2_out == r_q.addr[15:8]))
    else $error("port two lost the pointer high byte");
  a_addr_phase: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_bus.ale && !r_q.use_ri) |-> (o_bus.p0_oe && o_bus.p2_oe && ({o_bus.p2_out, o_bus.p0_out} == r_q.addr)))
    else $error("address phase lost the pointer");
  a_ri_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    (x_take && i_xreq.use_ri) |=> (o_xdone || (r_q.addr[15:8] == 8'h00)))
    else $error("register-indirect access carried a high address byte");

  // Internal data space and pointer increment checks
  a_stack_ram: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ireq.valid && i_ireq.mode != DPX_DIRECT) |=> !o_sfr_other && !r_q.rd_sfr)
    else $error("indirect or stack access reached register space");
  a_direct_sfr: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ireq.valid && i_ireq.mode == DPX_DIRECT && i_ireq.addr > 8'h7f) |=> r_q.rd_sfr)
    else $error("direct high address missed register space");
  a_lower_both: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ireq.valid && (i_ireq.addr <= 8'h7f)) |=> (!r_q.rd_sfr && !o_sfr_other))
    else $error("lower RAM address reached register space");
  a_inc_selected: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_dpcmd.op == DPX_OP_INC && r_q.sel) |=> $stable(r_q.dp0) && (r_q.dp1 == $past(r_q.dp1) + 16'h0001))
    else $error("increment hit the unselected pointer");

  // Scenario covers
  c_int_access: cover property (@(posedge i_mclk) disable iff (i_rst) x_take && x_hit);
  c_ext_read:   cover property (@(posedge i_mclk) disable iff (i_rst) $rose(!o_bus.rd_n));
  c_long_write: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(!o_bus.wr_n) && r_q.stretch);
  c_sel_flip:   cover property (@(posedge i_mclk) disable iff (i_rst) $changed(r_q.sel));
  c_ri_ext:     cover property (@(posedge i_mclk) disable iff (i_rst) o_bus.ale && r_q.use_ri);

endmodule : dpx_access

// [test/dpx_ext_mem.sv]
// Purpose: External data memory model on the multiplexed port zero / port two bus
// Assumes: Address latched while ale is high, strobes active low, one clock domain
// Notes:   Released port zero shows the inverse of its last value, never a held copy
`timescale 1ns/10ps

module dpx_ext_mem (
  input  wire logic              i_mclk,
  input  wire dpx_pkg::dpx_bus_t i_bus,
  output logic [7:0]             o_p0,
  output logic [15:0]            o_addr,
  output logic                   o_hi_en,
  output logic [7:0]             o_strb_len
);
  import dpx_pkg::*;

  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  logic [7:0] cnt_q  = 8'h00;

  // Latch address phase, store under write strobe, measure each strobe length
  always @(posedge i_mclk) begin
    if (i_bus.ale) begin
      o_addr  <= {(i_bus.p2_oe ? i_bus.p2_out : 8'h00), i_bus.p0_out};
      o_hi_en <= i_bus.p2_oe;
    end
    if (!i_bus.wr_n) mem[o_addr] <= i_bus.p0_out;
    if (!i_bus.rd_n || !i_bus.wr_n) cnt_q <= cnt_q + 8'h01;
    else if (cnt_q != 8'h00) begin
      o_strb_len <= cnt_q;
      cnt_q      <= 8'h00;
    end
    last_q <= o_p0;
  end

  // Data only inside the read strobe; outside it the line keeps changing so a late sample shows
  assign o_p0 = !i_bus.rd_n ? mem[o_addr] : ~last_q;
endmodule : dpx_ext_mem

// [test/dpx_access_tb.sv]
// Purpose: Self-checking bench for the dual pointer data memory access block
// Assumes: Bench drives inputs 1 ns after the rising edge
// Notes:   External latency is 10 cycles with short strobes, 34 stretched
`timescale 1ns/10ps

module dpx_access_tb;
  import dpx_pkg::*;

  logic        i_mclk  = 1'b0;
  logic        i_rst   = 1'b1;
  dpx_ireq_t   i_ireq  = '0;
  dpx_dpcmd_t  i_dpcmd = '0;
  dpx_xreq_t   i_xreq  = '0;
  logic [7:0]  o_irdata;
  logic [7:0]  o_xrdata;
  logic [7:0]  p0_in;
  logic [7:0]  strb_len;
  logic        o_sfr_other;
  logic        o_xbusy;
  logic        o_xdone;
  logic        hi_en;
  logic [15:0] o_data_pointer;
  logic [15:0] ext_addr;
  dpx_bus_t    o_bus;
  dpx_bus_t    bus_snap;
  int          n_fail = 0;
  int          total_checks = 0;
  int          lat;

  dpx_access #(.IRAM_BYTES(256)) dpx_access_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ireq(i_ireq), .o_irdata(o_irdata), .o_sfr_other(o_sfr_other),
    .i_dpcmd(i_dpcmd), .o_data_pointer(o_data_pointer), .i_xreq(i_xreq), .o_xbusy(o_xbusy), .o_xdone(o_xdone),
    .o_xrdata(o_xrdata), .i_p0_in(p0_in), .o_bus(o_bus));

  dpx_ext_mem dpx_ext_mem_inst (
    .i_mclk(i_mclk), .i_bus(o_bus), .o_p0(p0_in), .o_addr(ext_addr), .o_hi_en(hi_en),
    .o_strb_len(strb_len));

  // 50 ns period
  always #25 i_mclk = ~i_mclk;

  task automatic print_verdict;
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick

  // One internal access after an idle edge, so valid never drops and rises in one step; data settled on return
  task automatic iacc(input logic wr, input dpx_amode_t m, input logic [7:0] a, input logic [7:0] d);
    tick();
    i_ireq = '{1'b1, wr, m, a, d};
    tick();
    i_ireq.valid = 1'b0;
  endtask : iacc

  task automatic dp(input dpx_dpop_t op, input logic [15:0] v);
    tick();
    i_dpcmd = '{op, v};
    tick();
    i_dpcmd.op = DPX_OP_NONE;
  endtask : dp

  // Move-external access; pointer form loads the selected pointer first, lat counts to done
  task automatic xacc(input logic wr, input logic ri, input logic [15:0] a, input logic [7:0] d);
    if (!ri) dp(DPX_OP_LOAD, a);
    else     tick();
    bus_snap = o_bus;
    i_xreq   = '{1'b1, wr, ri, a[7:0], d};
    lat      = 0;
    do begin
      tick();
      i_xreq.valid = 1'b0;
      lat++;
    end while (o_xdone !== 1'b1 && lat < 100);
    if (lat >= 100) begin
      n_fail++;
      $display("[ERR] %0t no done", $time);
      print_verdict();
    end
  endtask : xacc

  initial begin
    repeat (4) tick();
    i_rst = 1'b0;
    iacc(1'b0, DPX_DIRECT, PSEL_OFS, 8'h00);
    chk(o_irdata, 8'h00, "psel reset");
    iacc(1'b0, DPX_DIRECT, MCTL_OFS, 8'h00);
    chk(o_irdata, 8'h08, "mctl reset");
    // Two pointers, each only touched while selected
    dp(DPX_OP_LOAD, 16'h1234);
    iacc(1'b1, DPX_DIRECT, PSEL_OFS, 8'h0d);
    iacc(1'b0, DPX_DIRECT, PSEL_OFS, 8'h00);
    chk(o_irdata, 8'h09, "psel bits");
    dp(DPX_OP_LOAD, 16'h0300);
    dp(DPX_OP_INC, 16'h0000);
    chk(o_data_pointer, 16'h0301, "ptr one inc");
    iacc(1'b1, DPX_DIRECT, PSEL_OFS, 8'h08);
    chk(o_data_pointer, 16'h1234, "ptr zero kept");
    iacc(1'b1, DPX_DIRECT, PSEL_OFS, 8'h00);
    chk(o_data_pointer, 16'h1234, "flag only write");
    iacc(1'b0, DPX_DIRECT, PSEL_OFS, 8'h00);
    chk(o_irdata, 8'h00, "flag cleared");
    // Upper RAM versus special registers, lower RAM both ways, stack
    iacc(1'b1, DPX_INDIRECT, 8'h90, 8'h5a);
    iacc(1'b0, DPX_DIRECT, 8'h90, 8'h00);
    chk(o_sfr_other, 1'b1, "other sfr");
    iacc(1'b0, DPX_INDIRECT, 8'h90, 8'h00);
    chk(o_irdata, 8'h5a, "upper ram");
    iacc(1'b1, DPX_DIRECT, 8'h10, 8'hc3);
    iacc(1'b0, DPX_INDIRECT, 8'h10, 8'h00);
    chk(o_irdata, 8'hc3, "lower ram");
    xacc(1'b1, 1'b0, 16'h00f0, 8'h11);
    iacc(1'b1, DPX_STACK, 8'hf0, 8'h77);
    iacc(1'b0, DPX_INDIRECT, 8'hf0, 8'h00);
    chk(o_irdata, 8'h77, "stack ram");
    xacc(1'b0, 1'b0, 16'h00f0, 8'h00);
    chk(o_xrdata, 8'h11, "stack not expanded_ram");
    // Expanded RAM on-chip, bus pins untouched
    xacc(1'b1, 1'b0, 16'h02ff, 8'h3c);
    chk(lat, 1, "expanded_ram wr lat");
    chk(o_bus, bus_snap, "bus quiet");
    xacc(1'b0, 1'b0, 16'h02ff, 8'h00);
    chk(o_xrdata, 8'h3c, "expanded_ram rd");
    xacc(1'b1, 1'b1, 16'h0020, 8'h6b);
    xacc(1'b0, 1'b0, 16'h0020, 8'h00);
    chk(o_xrdata, 8'h6b, "ri to expanded_ram");
    // Every size code: last visible byte on-chip; codes 0 to 2 also check next byte external with full address
    for (int s = 0; s < 4; s++) begin
      iacc(1'b1, DPX_DIRECT, MCTL_OFS, 8'(s * 4));
      xacc(1'b0, 1'b0, 16'((s + 1) * 256 - 1), 8'h00);
      chk(lat, 1, "size top");
      if (s < 3) begin
        xacc(1'b1, 1'b0, 16'((s + 1) * 256), 8'(8'ha0 + s));
        chk(lat, 10, "ext wr lat");
        chk(o_xbusy, 1'b0, "idle at done");
        chk({hi_en, ext_addr}, 17'h10000 + (s + 1) * 256, "ext addr");
        chk(strb_len, 8'd6, "short strobe");
        chk(dpx_ext_mem_inst.mem[(s + 1) * 256], 8'(8'ha0 + s), "ext mem");
        xacc(1'b0, 1'b0, 16'((s + 1) * 256), 8'h00);
        chk(o_xrdata, 8'(8'ha0 + s), "ext rd");
      end
    end
    // External select: register-indirect goes out with 8-bit address
    iacc(1'b1, DPX_DIRECT, MCTL_OFS, 8'h0e);
    xacc(1'b1, 1'b1, 16'h0040, 8'h99);
    chk(lat, 10, "ri ext lat");
    chk({hi_en, ext_addr}, 17'h00040, "ri ext addr");
    xacc(1'b0, 1'b0, 16'h0020, 8'h00);
    chk(lat, 10, "ptr ext sel");
    // Stretched strobe
    iacc(1'b1, DPX_DIRECT, MCTL_OFS, 8'h2e);
    xacc(1'b0, 1'b1, 16'h0040, 8'h00);
    chk(lat, 34, "long lat");
    chk(strb_len, 8'd30, "long strobe");
    chk(o_xrdata, 8'h99, "long rd");
    print_verdict();
  end
endmodule : dpx_access_tb
